// >>> common/byte_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	logic last;
	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface : byte_stream_if
`default_nettype wire

// >>> common/frame_codec_pkg.sv
`default_nettype none
package frame_codec_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_LEN_HI, ST_LEN_LO, ST_BODY, ST_CHECK} parse_state_t;
	typedef struct packed {
		parse_state_t st;
		logic [15:0] idx;
		logic [15:0] remain;
		logic [7:0] sum;
		logic [7:0] ftype;
		logic [7:0] fid;
		logic [15:0] name;
		logic [31:0] value;
		logic [15:0] vcount;
		logic [63:0] dest64;
		logic [15:0] dest16;
		logic [7:0] radius;
		logic bcast;
		logic coord;
		logic [7:0] eff_radius;
		logic no_retry;
		logic app_sec;
		logic ext_timeout;
		logic [15:0] pay_count;
		logic tx_start;
		logic tx_end;
		logic tx_good;
		logic too_long;
		logic [7:0] tx_id;
		logic tx_unknown;
		logic [15:0] tx_addr16;
		logic param_write;
		logic param_apply;
		logic param_read;
		logic pend;
		logic frame_err;
		logic value_err;
		logic resp_valid;
		logic [7:0] resp_type;
		logic [7:0] resp_id;
		logic [15:0] resp_name;
		logic [31:0] resp_data;
		logic resp_ok;
		logic stat_pend;
		logic [7:0] stat_id;
		logic [15:0] stat_addr;
		logic stat_ok;
	} codec_state_t;
endpackage : frame_codec_pkg
`default_nettype wire

// >>> common/frame_codec_regs.svh
// What this block does
// - Type 0x08 frame is a local parameter command, read or write.
// - Parameter write by type 0x08 takes effect at once.
// - Command frame with no value bytes is a parameter read, except the AC apply command.
// - Offsets 5 and 6 hold the two ASCII name bytes.
// - Bytes from offset 7 to checksum are the value; none means read, unless the name is AC.
// - Type 0x09 queues a write until a 0x08 frame or apply command.
// - A read by type 0x09 is answered at once, never queued.
// - Both parameter frame types are answered with type 0x88.
// - Offset 4 is the frame id; zero suppresses every response.
// - Numeric values of one, two or four zero-padded bytes are accepted.
// - Type 0x10 sends the payload as one radio packet to the destination.
// - 64-bit destination 0x000000000000FFFF means broadcast.
// - Coordinator: zero 64-bit with 0xFFFE, or own 64-bit with 0x0000.
// - Unknown 16-bit destination: report discovered address in 0x8B on success.
// - 64-bit destination at offsets 5 to 12, most significant first.
// - 16-bit destination high at 13, low at 14; 0xFFFE means unknown.
// - Offset 15 is broadcast hops, zero means configured maximum; unicast ignores it.
// - Option bits: 0x01 no retries, 0x20 encryption, 0x40 extended timeout.
// - Encryption lowers the payload limit by four bytes.
// - Source routing lowers the payload limit by two bytes per hop.
// - Payload runs from offset 17 to the byte before the checksum.
// - Length counts type through last data byte only.
`ifndef FRAME_CODEC_REGS_SVH
`define FRAME_CODEC_REGS_SVH
`define START_DELIM 8'h7E
`define TYPE_PARAM_NOW 8'h08
`define TYPE_PARAM_QUEUE 8'h09
`define TYPE_TX_REQ 8'h10
`define TYPE_PARAM_RESP 8'h88
`define TYPE_TX_STATUS 8'h8B
`define OFS_TYPE 16'h0003
`define OFS_ID 16'h0004
`define OFS_NAME_HI 16'h0005
`define OFS_NAME_LO 16'h0006
`define OFS_VALUE 16'h0007
`define OFS_DEST64_LAST 16'h000C
`define OFS_DEST16_HI 16'h000D
`define OFS_DEST16_LO 16'h000E
`define OFS_RADIUS 16'h000F
`define OFS_OPTIONS 16'h0010
`define OFS_PAYLOAD 16'h0011
`define BCAST_ADDR64 64'h0000_0000_0000_FFFF
`define COORD_ADDR64 64'h0000_0000_0000_0000
`define UNKNOWN_ADDR16 16'hFFFE
`define COORD_ADDR16 16'h0000
`define OPT_NO_RETRY 0
`define OPT_APP_SEC 5
`define OPT_EXT_TIMEOUT 6
`define CHECKSUM_GOOD 8'hFF
`define APP_SEC_OVERHEAD 16'h0004
`define HOP_OVERHEAD 16'h0002
`define NAME_APPLY 16'h4143
`define VALUE_MAX_BYTES 16'h0004
`define FRAME_ID_NONE 8'h00
`endif

// >>> core/host_api_frame_codec.sv
`timescale 1ns/100ps
`default_nettype none
`include "frame_codec_regs.svh"
module host_api_frame_codec (
	input wire logic clock, // 20 MHz system clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [7:0] rx_data, // Host frame byte
	input wire logic rx_valid, // Host byte offered
	output logic rx_ready, // Byte taken when valid
	output logic [15:0] param_name, // Addressed parameter name
	output logic [31:0] param_value, // Value to write
	output logic param_write, // Stage value pulse
	output logic param_apply, // Commit staged values pulse
	output logic param_read, // Read done pulse
	input wire logic [31:0] param_rdata, // Current value of param_name
	output logic param_pending, // Queued change waiting
	input wire logic apply_changes_cmd, // Apply queued changes pulse
	input wire logic [7:0] max_hops_param, // Configured hop limit
	input wire logic encryption_enable_param, // Encryption allowed
	input wire logic [15:0] max_payload_query, // Reported payload limit
	input wire logic [7:0] route_hops, // Intermediate source route hops
	input wire logic [63:0] coord_addr, // Coordinator 64-bit address
	output logic tx_start, // Header complete pulse
	output logic [63:0] tx_dest64, // Destination 64-bit address
	output logic [15:0] tx_dest16, // Destination 16-bit address
	output logic [7:0] tx_radius, // Effective broadcast hops
	output logic tx_broadcast, // Broadcast destination
	output logic tx_to_coord, // Coordinator destination
	output logic tx_no_retry, // Retries disabled
	output logic tx_app_sec, // Encryption requested and allowed
	output logic tx_ext_timeout, // Extended timeout
	output logic [7:0] pay_data, // Payload byte
	output logic pay_last, // Last payload byte
	output logic pay_valid, // Payload byte offered
	input wire logic pay_ready, // Radio takes payload byte
	output logic tx_end, // Frame end pulse
	output logic tx_good, // Checksum matched
	output logic tx_too_long, // Payload over limit
	input wire logic tx_done, // Radio finished pulse
	input wire logic tx_ok, // Radio delivery succeeded
	input wire logic [15:0] tx_found_addr16, // Discovered 16-bit address
	output logic resp_valid, // Response ready
	input wire logic resp_ready, // Response taken
	output logic [7:0] resp_type, // Response frame type
	output logic [7:0] resp_id, // Response frame id
	output logic [15:0] resp_name, // Echoed parameter name
	output logic [31:0] resp_data, // Read value or 16-bit address
	output logic resp_ok, // Command or delivery succeeded
	output logic frame_error, // Checksum mismatch pulse
	output logic value_error // Oversized value pulse
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] payload_limit(input logic [15:0] max_pay, input logic sec,
		input logic [7:0] hops);
		logic [15:0] cut;
		cut = (sec ? `APP_SEC_OVERHEAD : 16'h0000) + 16'(hops) * `HOP_OVERHEAD;
		payload_limit = (cut > max_pay) ? 16'h0000 : max_pay - cut;
	endfunction : payload_limit

	frame_codec_pkg::codec_state_t s_reg;
	frame_codec_pkg::codec_state_t s_next;
	byte_stream_if #(.WIDTH(8)) to_buf ();
	byte_stream_if #(.WIDTH(8)) from_buf ();
	logic take;
	logic is_payload;
	logic is_param;
	logic [7:0] sum_next;
	logic resp_free;

	two_entry_buffer #(.WIDTH(8)) pay_buf (
		.clock(clock),
		.reset_n(reset_n),
		.fill(to_buf.snk),
		.drain(from_buf.src)
	);

	// ----------------------------------------------------------------
	// Payload path
	// ----------------------------------------------------------------
	assign is_param = (s_reg.ftype == `TYPE_PARAM_NOW) || (s_reg.ftype == `TYPE_PARAM_QUEUE);
	assign is_payload = (s_reg.st == frame_codec_pkg::ST_BODY) && (s_reg.ftype == `TYPE_TX_REQ)
		&& (s_reg.idx >= `OFS_PAYLOAD);
	assign to_buf.valid = is_payload && rx_valid;
	assign to_buf.data = rx_data;
	assign to_buf.last = (s_reg.remain == 16'h0001);
	assign pay_valid = from_buf.valid;
	assign pay_data = from_buf.data;
	assign pay_last = from_buf.last;
	assign from_buf.ready = pay_ready;

	// A pending response stalls the checksum byte, so no answer is overwritten
	assign rx_ready = is_payload ? to_buf.ready
		: !((s_reg.st == frame_codec_pkg::ST_CHECK) && s_reg.resp_valid);
	assign take = rx_valid && rx_ready;
	assign sum_next = s_reg.sum + rx_data;

	// ----------------------------------------------------------------
	// Parser and responder
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		resp_free = !s_reg.resp_valid || resp_ready;
		s_next.tx_start = 1'b0;
		s_next.tx_end = 1'b0;
		s_next.param_write = 1'b0;
		s_next.param_apply = 1'b0;
		s_next.param_read = 1'b0;
		s_next.frame_err = 1'b0;
		s_next.value_err = 1'b0;
		if (s_reg.resp_valid && resp_ready) begin
			s_next.resp_valid = 1'b0;
		end
		if (take) begin
			case (s_reg.st)
				frame_codec_pkg::ST_IDLE: begin
					if (rx_data == `START_DELIM) begin
						s_next.st = frame_codec_pkg::ST_LEN_HI;
					end
				end
				frame_codec_pkg::ST_LEN_HI: begin
					s_next.remain = {rx_data, 8'h00};
					s_next.st = frame_codec_pkg::ST_LEN_LO;
				end
				frame_codec_pkg::ST_LEN_LO: begin
					s_next.remain = {s_reg.remain[15:8], rx_data};
					s_next.idx = `OFS_TYPE;
					s_next.sum = 8'h00;
					s_next.ftype = 8'h00;
					s_next.fid = `FRAME_ID_NONE;
					s_next.vcount = 16'h0000;
					s_next.value = 32'h0000_0000;
					s_next.pay_count = 16'h0000;
					s_next.st = ({s_reg.remain[15:8], rx_data} == 16'h0000) ? frame_codec_pkg::ST_CHECK
						: frame_codec_pkg::ST_BODY;
				end
				frame_codec_pkg::ST_BODY: begin
					s_next.sum = sum_next;
					s_next.idx = s_reg.idx + 16'h0001;
					s_next.remain = s_reg.remain - 16'h0001;
					if (s_reg.remain == 16'h0001) begin
						s_next.st = frame_codec_pkg::ST_CHECK;
					end
					if (s_reg.idx == `OFS_TYPE) begin
						s_next.ftype = rx_data;
					end else if (s_reg.idx == `OFS_ID) begin
						s_next.fid = rx_data;
					end else if (is_param) begin
						if (s_reg.idx == `OFS_NAME_HI) begin
							s_next.name[15:8] = rx_data;
						end else if (s_reg.idx == `OFS_NAME_LO) begin
							s_next.name[7:0] = rx_data;
						end else begin
							// Shifting in keeps 1, 2 and 4 byte padded forms equal
							s_next.value = {s_reg.value[23:0], rx_data};
							s_next.vcount = s_reg.vcount + 16'h0001;
						end
					end else if (s_reg.ftype == `TYPE_TX_REQ) begin
						if (s_reg.idx <= `OFS_DEST64_LAST) begin
							s_next.dest64 = {s_reg.dest64[55:0], rx_data};
						end else if (s_reg.idx == `OFS_DEST16_HI) begin
							s_next.dest16[15:8] = rx_data;
						end else if (s_reg.idx == `OFS_DEST16_LO) begin
							s_next.dest16[7:0] = rx_data;
						end else if (s_reg.idx == `OFS_RADIUS) begin
							s_next.radius = rx_data;
						end else if (s_reg.idx == `OFS_OPTIONS) begin
							s_next.bcast = (s_reg.dest64 == `BCAST_ADDR64);
							s_next.coord = ((s_reg.dest64 == `COORD_ADDR64) && (s_reg.dest16 == `UNKNOWN_ADDR16))
								|| ((s_reg.dest64 == coord_addr) && (s_reg.dest16 == `COORD_ADDR16));
							if (s_reg.dest64 != `BCAST_ADDR64) begin
								s_next.eff_radius = 8'h00;
							end else if (s_reg.radius == 8'h00) begin
								s_next.eff_radius = max_hops_param;
							end else begin
								s_next.eff_radius = s_reg.radius;
							end
							// Unused option bits are taken as zero and not looked at
							s_next.no_retry = rx_data[`OPT_NO_RETRY];
							s_next.app_sec = rx_data[`OPT_APP_SEC] && encryption_enable_param;
							s_next.ext_timeout = rx_data[`OPT_EXT_TIMEOUT];
							s_next.tx_start = 1'b1;
						end else begin
							s_next.pay_count = s_reg.pay_count + 16'h0001;
						end
					end
				end
				frame_codec_pkg::ST_CHECK: begin
					s_next.st = frame_codec_pkg::ST_IDLE;
					if (sum_next != `CHECKSUM_GOOD) begin
						s_next.frame_err = 1'b1;
					end
					if (s_reg.ftype == `TYPE_TX_REQ) begin
						// Payload already streamed; the radio drops it on a bad checksum
						s_next.tx_end = 1'b1;
						s_next.tx_good = (sum_next == `CHECKSUM_GOOD);
						s_next.too_long = s_reg.pay_count > payload_limit(max_payload_query,
							s_reg.app_sec, route_hops);
						s_next.tx_id = s_reg.fid;
						s_next.tx_unknown = (s_reg.dest16 == `UNKNOWN_ADDR16);
						s_next.tx_addr16 = s_reg.dest16;
					end else if (is_param && (sum_next == `CHECKSUM_GOOD)) begin
						s_next.resp_ok = 1'b1;
						s_next.resp_data = 32'h0000_0000;
						if (s_reg.name == `NAME_APPLY) begin
							s_next.param_apply = 1'b1;
							s_next.pend = 1'b0;
						end else if (s_reg.vcount == 16'h0000) begin
							s_next.param_read = 1'b1;
							s_next.resp_data = param_rdata;
							if (s_reg.ftype == `TYPE_PARAM_NOW) begin
								s_next.param_apply = s_reg.pend;
								s_next.pend = 1'b0;
							end
						end else if (s_reg.vcount > `VALUE_MAX_BYTES) begin
							s_next.value_err = 1'b1;
							s_next.resp_ok = 1'b0;
						end else begin
							s_next.param_write = 1'b1;
							if (s_reg.ftype == `TYPE_PARAM_NOW) begin
								s_next.param_apply = 1'b1;
								s_next.pend = 1'b0;
							end else begin
								s_next.pend = 1'b1;
							end
						end
						if (s_reg.fid != `FRAME_ID_NONE) begin
							s_next.resp_valid = 1'b1;
							s_next.resp_type = `TYPE_PARAM_RESP;
							s_next.resp_id = s_reg.fid;
							s_next.resp_name = s_reg.name;
						end
					end
				end
				default: begin
					s_next.st = frame_codec_pkg::ST_IDLE;
				end
			endcase
		end
		if (apply_changes_cmd) begin
			s_next.param_apply = 1'b1;
			// Set wins: a queued write staged in this same cycle stays pending
			s_next.pend = s_next.pend && s_next.param_write;
		end
		// Delivery report waits for the response slot; a new report arriving
		// in the drain cycle is kept, not lost
		if (s_reg.stat_pend && resp_free && !s_next.resp_valid) begin
			s_next.stat_pend = 1'b0;
			s_next.resp_valid = 1'b1;
			s_next.resp_type = `TYPE_TX_STATUS;
			s_next.resp_id = s_reg.stat_id;
			s_next.resp_name = 16'h0000;
			s_next.resp_data = {16'h0000, s_reg.stat_addr};
			s_next.resp_ok = s_reg.stat_ok;
		end
		if (tx_done && (s_reg.tx_id != `FRAME_ID_NONE)) begin
			s_next.stat_pend = 1'b1;
			s_next.stat_id = s_reg.tx_id;
			s_next.stat_ok = tx_ok;
			s_next.stat_addr = (tx_ok && s_reg.tx_unknown) ? tx_found_addr16 : s_reg.tx_addr16;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign param_name = s_reg.name;
	assign param_value = s_reg.value;
	assign param_write = s_reg.param_write;
	assign param_apply = s_reg.param_apply;
	assign param_read = s_reg.param_read;
	assign param_pending = s_reg.pend;
	assign tx_start = s_reg.tx_start;
	assign tx_dest64 = s_reg.dest64;
	assign tx_dest16 = s_reg.dest16;
	assign tx_radius = s_reg.eff_radius;
	assign tx_broadcast = s_reg.bcast;
	assign tx_to_coord = s_reg.coord;
	assign tx_no_retry = s_reg.no_retry;
	assign tx_app_sec = s_reg.app_sec;
	assign tx_ext_timeout = s_reg.ext_timeout;
	assign tx_end = s_reg.tx_end;
	assign tx_good = s_reg.tx_good;
	assign tx_too_long = s_reg.too_long;
	assign resp_valid = s_reg.resp_valid;
	assign resp_type = s_reg.resp_type;
	assign resp_id = s_reg.resp_id;
	assign resp_name = s_reg.resp_name;
	assign resp_data = s_reg.resp_data;
	assign resp_ok = s_reg.resp_ok;
	assign frame_error = s_reg.frame_err;
	assign value_error = s_reg.value_err;
endmodule : host_api_frame_codec
`default_nettype wire

// >>> core/two_entry_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(parameter int WIDTH = 8) (
	input wire logic clock, // System clock
	input wire logic reset_n, // Asynchronous reset
	byte_stream_if.snk fill, // Filling side
	byte_stream_if.src drain // Draining side
);
	typedef struct packed {
		logic [WIDTH:0] head;
		logic [WIDTH:0] tail;
		logic [1:0] count;
	} buf_state_t;

	buf_state_t s_reg;
	buf_state_t s_next;
	logic push;
	logic pop;

	assign fill.ready = (s_reg.count != 2'h2);
	assign drain.valid = (s_reg.count != 2'h0);
	assign drain.data = s_reg.head[WIDTH-1:0];
	assign drain.last = s_reg.head[WIDTH];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	always_comb begin
		s_next = s_reg;
		if (pop && !push) begin
			s_next.head = s_reg.tail;
			s_next.count = s_reg.count - 2'h1;
		end else if (push && !pop) begin
			if (s_reg.count == 2'h0) begin
				s_next.head = {fill.last, fill.data};
			end else begin
				s_next.tail = {fill.last, fill.data};
			end
			s_next.count = s_reg.count + 2'h1;
		end else if (push && pop) begin
			// Full buffer cannot push, so count is one here
			s_next.head = {fill.last, fill.data};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : two_entry_buffer
`default_nettype wire

// >>> testbench/host_api_frame_codec_checker.sv
`timescale 1ns/100ps
`default_nettype none
module host_api_frame_codec_checker (
	input wire logic clock, // Clock
	input wire logic reset_n, // Reset
	input wire logic param_write, // Stage
	input wire logic param_apply, // Commit
	input wire logic param_pending, // Queued
	input wire logic apply_changes_cmd, // Apply
	input wire logic [63:0] coord_addr, // Coordinator
	input wire logic tx_start, // Header
	input wire logic [63:0] tx_dest64, // Dest
	input wire logic [15:0] tx_dest16, // Dest
	input wire logic [7:0] tx_radius, // Hops
	input wire logic tx_broadcast, // Broadcast
	input wire logic tx_to_coord, // To coordinator
	input wire logic pay_valid, // Offered
	input wire logic pay_ready, // Taken
	input wire logic [7:0] pay_data, // Byte
	input wire logic resp_valid, // Response
	input wire logic resp_ready, // Taken
	input wire logic [7:0] resp_type, // Type
	input wire logic [7:0] resp_id // Id
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	AST_RESP_HOLD: assert property (resp_valid && !resp_ready |=> resp_valid && $stable({resp_type, resp_id}))
		else $error("response dropped early");
	AST_QUEUE_PEND: assert property (param_write && !param_apply |=> param_pending)
		else $error("queued write not pending");
	AST_APPLY_CMD: assert property (apply_changes_cmd |=> param_apply && (!param_pending || param_write))
		else $error("apply command ignored");
	AST_PAY_HOLD: assert property (pay_valid && !pay_ready |=> pay_valid && $stable(pay_data))
		else $error("payload byte lost");
	AST_RADIUS_UNI: assert property (tx_start && !tx_broadcast |-> tx_radius == 8'h00)
		else $error("unicast radius used");
	AST_BCAST: assert property (tx_start |-> tx_broadcast == (tx_dest64 == 64'h0000_0000_0000_FFFF))
		else $error("broadcast decode wrong");
	AST_COORD: assert property (tx_start |-> tx_to_coord == (tx_dest64 == 64'h0 && tx_dest16 == 16'hFFFE
			|| tx_dest64 == coord_addr && tx_dest16 == 16'h0))
		else $error("coordinator decode wrong");
	AST_RESP_ID: assert property (resp_valid |-> resp_id != 8'h00)
		else $error("response for zero id");
	cover property (tx_start && tx_broadcast);
	cover property (param_write && !param_apply);
	cover property (pay_valid && !pay_ready);
endmodule : host_api_frame_codec_checker
bind host_api_frame_codec host_api_frame_codec_checker chk (.clock, .reset_n, .param_write, .param_apply,
	.param_pending, .apply_changes_cmd, .coord_addr, .tx_start, .tx_dest64, .tx_dest16, .tx_radius,
	.tx_broadcast, .tx_to_coord, .pay_valid, .pay_ready, .pay_data, .resp_valid, .resp_ready, .resp_type, .resp_id);
`default_nettype wire

// >>> testbench/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic clock, // Clock
	output logic [7:0] rx_data, // Byte
	output logic rx_valid, // Offered
	input wire logic rx_ready, // Taken
	input wire logic resp_valid, // Response
	output logic resp_ready, // Taken
	input wire logic [7:0] resp_type, // Type
	input wire logic [7:0] resp_id, // Id
	input wire logic [31:0] resp_data, // Data
	input wire logic resp_ok // Status
);
	logic [7:0] got_type, got_id;
	logic [31:0] got_data;
	logic got_ok;
	int got_n = 0;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		resp_ready = 1'b0;
	end
	// Half-rate acceptance: resp_ready toggles every cycle, so a response may wait one cycle
	always @(posedge clock) begin
		resp_ready <= ~resp_ready;
		if (resp_valid && resp_ready) begin
			{got_type, got_id, got_data, got_ok} <= {resp_type, resp_id, resp_data, resp_ok};
			got_n <= got_n + 1;
		end
	end
	task automatic send(input logic [7:0] f[$]);
		@(posedge clock);
		foreach (f[i]) begin
			rx_data <= f[i];
			rx_valid <= 1'b1;
			@(posedge clock iff rx_ready);
		end
		rx_data <= ~f[f.size() - 1];
		rx_valid <= 1'b0;
	endtask : send
endmodule : host_model
`default_nettype wire

// >>> testbench/test_host_api_frame_codec.sv
`timescale 1ns/100ps
`default_nettype none
module test_host_api_frame_codec;
	typedef logic [7:0] byte_q_t[$];
	typedef struct {logic [7:0] ft; logic [7:0] id; logic [15:0] nm; int nv; logic [31:0] v; logic ap; logic pd;} row_t;
	logic clock = 0, reset_n = 0, rx_valid, rx_ready, param_write, param_apply, param_read, param_pending;
	logic [7:0] rx_data, tx_radius, pay_data, resp_type, resp_id, max_hops_param = 8'h07, route_hops = 8'h00;
	logic [15:0] param_name, tx_dest16, resp_name, max_payload_query = 16'h0014, tx_found_addr16 = 16'h0000;
	logic [31:0] param_value, resp_data, param_rdata = 32'h0;
	logic [63:0] tx_dest64, coord_addr = 64'h0000_0000_0000_0A0B;
	logic apply_changes_cmd = 0, encryption_enable_param = 1, tx_start, tx_broadcast, tx_to_coord, tx_no_retry;
	logic tx_app_sec, tx_ext_timeout, pay_last, pay_valid, pay_ready = 0, tx_end, tx_good, tx_too_long;
	logic tx_done = 0, tx_ok = 0, resp_valid, resp_ready, resp_ok, frame_error, value_error;
	logic wr_seen, rd_seen, ap_seen, ve_seen, fe_seen;
	logic [12:0] hdr;
	logic [1:0] tl;
	logic [8:0] pq[$];
	int failures = 0, checks_done = 0;
	row_t rows[6] = '{'{8'h08, 8'h01, 16'h4E4A, 1, 32'h05, 1, 0}, '{8'h09, 8'h02, 16'h4244, 1, 32'h07, 0, 1},
		'{8'h09, 8'h03, 16'h4244, 0, 32'h0, 0, 1}, '{8'h08, 8'h04, 16'h4E48, 0, 32'h0, 1, 0},
		'{8'h08, 8'h05, 16'h4E4A, 2, 32'h05, 1, 0}, '{8'h09, 8'h06, 16'h4E4A, 4, 32'h05, 0, 1}};
	host_api_frame_codec dut (.clock, .reset_n, .rx_data, .rx_valid, .rx_ready, .param_name, .param_value,
		.param_write, .param_apply, .param_read, .param_rdata, .param_pending, .apply_changes_cmd, .max_hops_param,
		.encryption_enable_param, .max_payload_query, .route_hops, .coord_addr, .tx_start, .tx_dest64, .tx_dest16,
		.tx_radius, .tx_broadcast, .tx_to_coord, .tx_no_retry, .tx_app_sec, .tx_ext_timeout, .pay_data, .pay_last,
		.pay_valid, .pay_ready, .tx_end, .tx_good, .tx_too_long, .tx_done, .tx_ok, .tx_found_addr16, .resp_valid,
		.resp_ready, .resp_type, .resp_id, .resp_name, .resp_data, .resp_ok, .frame_error, .value_error);
	host_model host (.clock, .rx_data, .rx_valid, .rx_ready, .resp_valid, .resp_ready, .resp_type, .resp_id,
		.resp_data, .resp_ok);
	// ------------------------------
	// Clock, monitors and helpers
	// ------------------------------
	always #25 clock = ~clock;
	// The radio side stalls every other cycle so the buffer fills and back-pressures
	always @(posedge clock) begin
		pay_ready <= ~pay_ready;
		if (param_write) wr_seen <= 1'b1;
		if (param_read) rd_seen <= 1'b1;
		if (param_apply) ap_seen <= 1'b1;
		if (value_error) ve_seen <= 1'b1;
		if (frame_error) fe_seen <= 1'b1;
		if (tx_start) hdr <= {tx_broadcast, tx_to_coord, tx_no_retry, tx_app_sec, tx_ext_timeout, tx_radius};
		if (tx_end) tl <= {tx_good, tx_too_long};
		if (pay_valid && pay_ready) pq.push_back({pay_last, pay_data});
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic clr;
		{wr_seen, rd_seen, ap_seen, ve_seen, fe_seen, hdr, tl} = '0;
	endtask : clr
	function automatic byte_q_t mk(input logic [7:0] t, input byte_q_t d);
		logic [7:0] s;
		byte_q_t f;
		s = t;
		foreach (d[k]) s += d[k];
		f = {8'h7E, 8'h00, 8'(d.size() + 1), t};
		f = {f, d, 8'hFF - s};
		return f;
	endfunction : mk
	task automatic wait_resp(input int n0);
		for (int k = 0; k < 20 && host.got_n == n0; k++) @(negedge clock);
		check(host.got_n, n0 + 1);
	endtask : wait_resp
	task automatic tx(input logic [63:0] a, input logic [15:0] b, input logic [7:0] rad, opt, id, input int n,
			input logic [14:0] e);
		byte_q_t d;
		d = {id};
		for (int k = 7; k >= 0; k--) d.push_back(a[8*k +: 8]);
		d = {d, b[15:8], b[7:0], rad, opt};
		for (int k = 0; k < n; k++) d.push_back(8'(8'h30 + k));
		clr();
		host.send(mk(8'h10, d));
		repeat (8) @(negedge clock);
		check({hdr, tl}, e);
		check(pq.size(), n);
		check(tx_dest64, a);
		check(tx_dest16, b);
		for (int k = 0; k < n; k++) check(pq[k], {k == n - 1, 8'(8'h30 + k)});
		pq.delete();
		$display("Transmit to %h done", a);
	endtask : tx
	initial begin
		#(50 * 4000);
		failures++;
		tally_and_finish();
	end
	// ------------------------------
	// Tests
	// ------------------------------
	initial begin
		byte_q_t d;
		int n0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		check({rx_ready, pay_valid, resp_valid, param_pending}, 4'b1000);
		$display("Reset test done");
		foreach (rows[i]) begin
			@(posedge clock);
			param_rdata <= {rows[i].nm, ~rows[i].nm};
			clr();
			n0 = host.got_n;
			d = {rows[i].id, rows[i].nm[15:8], rows[i].nm[7:0]};
			for (int k = rows[i].nv - 1; k >= 0; k--) d.push_back(rows[i].v[8*k +: 8]);
			host.send(mk(rows[i].ft, d));
			wait_resp(n0);
			check({host.got_type, host.got_id, host.got_ok}, {8'h88, rows[i].id, 1'b1});
			check(host.got_data, rows[i].nv == 0 ? {rows[i].nm, ~rows[i].nm} : 32'h0);
			check({wr_seen, ap_seen, param_pending}, {rows[i].nv != 0, rows[i].ap, rows[i].pd});
			check(rd_seen, rows[i].nv == 0);
			check({param_name, resp_name}, {2{rows[i].nm}});
			if (rows[i].nv != 0) check(param_value, rows[i].v);
			$display("Parameter row %0d done", i);
		end
		@(posedge clock);
		clr();
		apply_changes_cmd <= 1'b1;
		@(posedge clock);
		apply_changes_cmd <= 1'b0;
		repeat (2) @(negedge clock);
		check({ap_seen, param_pending}, 2'b10);
		n0 = host.got_n;
		clr();
		host.send(mk(8'h08, {8'h00, 8'h4E, 8'h4A, 8'h03}));
		repeat (10) @(negedge clock);
		check({host.got_n == n0, wr_seen, param_value}, {2'b11, 32'h03});
		clr();
		d = mk(8'h08, {8'h07, 8'h4E, 8'h4A, 8'h09});
		d[d.size() - 1] ^= 8'h01;
		host.send(d);
		repeat (10) @(negedge clock);
		check({host.got_n == n0, wr_seen, fe_seen}, 3'b101);
		clr();
		host.send(mk(8'h08, {8'h08, 8'h4E, 8'h4A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}));
		wait_resp(n0);
		check({host.got_ok, wr_seen, ve_seen}, 3'b001);
		$display("Error frame tests done");
		tx(64'h0000_0000_0000_FFFF, 16'hFFFE, 8'h00, 8'h21, 8'h11, 6, {5'b10110, 8'h07, 2'b10});
		n0 = host.got_n;
		@(posedge clock);
		{tx_done, tx_ok, tx_found_addr16} <= {2'b11, 16'h1A2B};
		@(posedge clock);
		tx_done <= 1'b0;
		wait_resp(n0);
		check({host.got_type, host.got_id, host.got_data, host.got_ok}, {16'h8B11, 32'h0000_1A2B, 1'b1});
		max_payload_query <= 16'h0009;
		tx(64'h0000_0000_0000_FFFF, 16'hFFFE, 8'h03, 8'h20, 8'h12, 6, {5'b10010, 8'h03, 2'b11});
		{max_payload_query, route_hops, encryption_enable_param} <= {16'h000A, 8'h02, 1'b0};
		tx(64'h0, 16'hFFFE, 8'h05, 8'h40, 8'h13, 7, {5'b01001, 8'h00, 2'b11});
		tx(coord_addr, 16'h0000, 8'h05, 8'h21, 8'h14, 1, {5'b01100, 8'h00, 2'b10});
		tally_and_finish();
	end
endmodule : test_host_api_frame_codec
`default_nettype wire
